// >>> dv/mmb_cpu.sv
// CPU core model issuing fetch and data bus requests.
`timescale 1ns/100ps
module mmb_cpu (
  input  wire logic   mclk,       // clock
  output logic [15:0] code_addr,  // fetch addr
  output logic        code_fetch, // fetch
  output logic [15:0] data_addr,  // data addr
  output logic        data_rd,    // read
  output logic        data_wr,    // write
  output logic [7:0]  data_wdata  // wdata
);
  initial {code_fetch, data_rd, data_wr, code_addr, data_addr} = '0;
  initial data_wdata = 8'h00;
  // One-cycle request; on release the strobes drop to 0, address and data lines show the inverse of the last value.
  task automatic req(input logic [2:0] k, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    {code_fetch, data_rd, data_wr, code_addr, data_addr, data_wdata} =
      {k, a, a, d};
    @(negedge mclk);
    {code_fetch, data_rd, data_wr, code_addr, data_addr, data_wdata} =
      {3'h0, ~a, ~a, ~d};
  endtask
endmodule

// >>> dv/mmb_map_bench.sv
// Self-checking bench of the memory map decoder.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module mmb_map_bench
  import mmb_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] code_addr, data_addr;
  logic [10:0] code_boot_ofs, data_boot_ofs;
  logic [7:0] data_wdata, data_rdata;
  logic code_fetch, data_rd, data_wr, data_rvalid, bootrom_map_enable;
  mmb_area_t code_area, data_area;
  mmb_cpu cpu (.mclk, .code_addr, .code_fetch, .data_addr, .data_rd,
    .data_wr, .data_wdata);
  mmb_map dut (.*);
  initial forever #5 mclk = ~mclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic t_reset;
    cpu.req(3'h2, MMB_FLASH_MAP_SHADOW_OFS, 8'h00);
    `CHK(data_rdata, 8'h40)
    cpu.req(3'h6, MMB_BOOT_HI, 8'h00);
    `CHK({data_rvalid, data_rdata}, 9'h1ff)
    `CHK(code_area, MMB_AREA_NONE)
  endtask
  task automatic t_commit;
    cpu.req(3'h1, MMB_FLASH_MAP_CONTROL_OFS, 8'h60);
    cpu.req(3'h1, MMB_MAP_COMMIT_KEY_OFS, 8'h55);
    `CHK(bootrom_map_enable, 1'b0)
    cpu.req(3'h1, MMB_MAP_COMMIT_KEY_OFS, 8'hd5);
    `CHK(bootrom_map_enable, 1'b1)
    cpu.req(3'h2, MMB_FLASH_MAP_SHADOW_OFS, 8'h00);
    `CHK(data_rdata, 8'h60)
    cpu.req(3'h6, MMB_BOOT_HI, 8'h00);
    `CHK(data_area, MMB_AREA_BOOT)
    `CHK(code_area, MMB_AREA_BOOT)
    `CHK(data_boot_ofs, 11'h7ff)
    `CHK(code_boot_ofs, 11'h7ff)
  endtask
  task automatic t_map;
    logic [15:0] a [7] = '{16'h8000, 16'hffff, 16'h003f, 16'h0e40,
      16'h0fff, 16'h0040, 16'h083f};
    logic [2:0] e [7] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
    foreach (a[i])
    begin
      cpu.req(3'h6, a[i], 8'h00);
      `CHK(data_area, e[i])
      `CHK(code_area, i < 2 ? 3'h4 : 3'h0)
    end
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_commit();
    t_map();
    report_and_stop();
  end
endmodule

// >>> dv/mmb_map_sva.sv
// Checker of the decoder ports.
`timescale 1ns/100ps
module mmb_map_sva
  import mmb_pkg::*;
(
  input wire logic        mclk,        // clock
  input wire logic        rst_n,       // reset
  input wire logic [15:0] code_addr,   // fetch addr
  input wire logic        code_fetch,  // fetch
  input wire logic [15:0] data_addr,   // data addr
  input wire logic        data_rd,     // read
  input wire logic        data_wr,     // write
  input wire logic [7:0]  data_wdata,  // wdata
  input wire mmb_area_t   code_area,   // fetch area
  input wire mmb_area_t   data_area,   // data area
  input wire logic [7:0]  data_rdata,  // rdata
  input wire logic        data_rvalid, // rvalid
  input wire logic        bootrom_map_enable // map
);
  wire en = bootrom_map_enable;
  wire acc = data_rd | data_wr;
  wire bw = data_addr inside {[MMB_BOOT_LO:MMB_BOOT_HI]};
  wire cb = code_fetch && code_addr[15:11] == 5'h02;
  wire sfr = data_addr <= MMB_SFR1_HI
    || data_addr inside {[MMB_SFR3_LO:MMB_SFR2_HI]};
  wire ram = data_addr inside {[MMB_RAM_LO:MMB_RAM_HI]};
  wire kw = data_wr && data_addr == MMB_MAP_COMMIT_KEY_OFS
    && data_wdata == MMB_COMMIT_KEY_FIELD;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  boot_map_a: assert property (acc && bw && en
    |=> data_area == MMB_AREA_BOOT) else $error("no boot area");
  boot_off_a: assert property (data_rd && bw && !en
    |=> data_rvalid && data_rdata == MMB_UNMAPPED_DATA) else $error("no ff");
  code_boot_a: assert property (cb |=> code_area ==
    ($past(en) ? MMB_AREA_BOOT : MMB_AREA_NONE)) else $error("fetch area");
  code_flash_a: assert property (code_fetch && code_addr[15]
    |=> code_area == MMB_AREA_FLASH) else $error("fetch not flash");
  data_flash_a: assert property (acc && data_addr[15]
    |=> data_area == MMB_AREA_FLASH) else $error("data not flash");
  sfr_area_a: assert property (acc && sfr
    |=> data_area == MMB_AREA_SFR) else $error("not sfr");
  ram_area_a: assert property (acc && ram
    |=> data_area == MMB_AREA_RAM) else $error("not ram");
  map_hold_a: assert property (!kw |=> $stable(en))
    else $error("map changed without key");
  sequence shadow_rd_s;
    data_rd && !data_wr && data_addr == MMB_FLASH_MAP_SHADOW_OFS;
  endsequence
  sequence shadow_ans_s;
    data_rvalid && data_rdata[MMB_BOOTROM_MAP_BIT] == $past(en);
  endsequence
  shadow_read_a: assert property (shadow_rd_s |=> shadow_ans_s)
    else $error("shadow does not match map");
endmodule
bind mmb_map mmb_map_sva chk (.*);

// >>> inc/mmb_pkg.sv
// Constants and types of the memory map and boot ROM control block.
package mmb_pkg;
  localparam logic [15:0] MMB_FLASH_MAP_CONTROL_OFS = 16'h0fd0;
  localparam logic [15:0] MMB_MAP_COMMIT_KEY_OFS    = 16'h0fd1;
  localparam logic [15:0] MMB_FLASH_MAP_SHADOW_OFS  = 16'h0fd2;
  localparam logic [7:0]  MMB_FLASH_MAP_RESET       = 8'h40;
  localparam logic [7:0]  MMB_COMMIT_KEY_FIELD      = 8'hd5;
  localparam int          MMB_BOOTROM_MAP_BIT       = 5;
  localparam logic [7:0]  MMB_UNMAPPED_DATA         = 8'hff;
  localparam logic [15:0] MMB_BOOT_LO               = 16'h1000;
  localparam logic [15:0] MMB_BOOT_HI               = 16'h17ff;
  localparam logic [15:0] MMB_FLASH_LO              = 16'h8000;
  localparam logic [15:0] MMB_SFR1_LO               = 16'h0000;
  localparam logic [15:0] MMB_SFR1_HI               = 16'h003f;
  localparam logic [15:0] MMB_SFR2_LO               = 16'h0f00;
  localparam logic [15:0] MMB_SFR2_HI               = 16'h0fff;
  localparam logic [15:0] MMB_SFR3_LO               = 16'h0e40;
  localparam logic [15:0] MMB_SFR3_HI               = 16'h0eff;
  localparam logic [15:0] MMB_RAM_LO                = 16'h0040;
  localparam logic [15:0] MMB_RAM_HI                = 16'h083f;
  localparam int          MMB_BOOT_AW               = 11;

  typedef enum logic [2:0] {
    MMB_AREA_NONE  = 3'h0,
    MMB_AREA_SFR   = 3'h1,
    MMB_AREA_RAM   = 3'h2,
    MMB_AREA_BOOT  = 3'h3,
    MMB_AREA_FLASH = 3'h4
  } mmb_area_t;
endpackage

// >>> logic/mmb_map.sv
// Memory map decoder with double-buffered boot ROM window control.
`timescale 1ns/100ps
module mmb_map
  import mmb_pkg::*;
(
  input  wire logic                    mclk,          // CPU clock
  input  wire logic                    rst_n,         // Async reset
  input  wire logic [15:0]             code_addr,     // Fetch address
  input  wire logic                    code_fetch,    // Fetch strobe
  input  wire logic [15:0]             data_addr,     // Data address
  input  wire logic                    data_rd,       // Data read strobe
  input  wire logic                    data_wr,       // Data write strobe
  input  wire logic [7:0]              data_wdata,    // Write data
  output mmb_area_t                    code_area,     // Fetch target
  output logic [MMB_BOOT_AW-1:0]       code_boot_ofs, // Boot ROM offset
  output mmb_area_t                    data_area,     // Data target
  output logic [MMB_BOOT_AW-1:0]       data_boot_ofs, // Boot ROM offset
  output logic [7:0]                   data_rdata,    // Register data
  output logic                         data_rvalid,   // rdata is valid
  output logic                         bootrom_map_enable // Committed
);

  // The whole state of the decoder lives in one register. The buffered
  // control byte and its committed copy sit side by side, so the key write
  // moves the setting across in a single clock. The area outputs are
  // registered, which means software sees the decode one cycle after the
  // address was presented.
  typedef struct packed {
    logic [7:0]             ctrl;
    logic [7:0]             committed;
    mmb_area_t              code_area;
    logic [MMB_BOOT_AW-1:0] code_boot_ofs;
    mmb_area_t              data_area;
    logic [MMB_BOOT_AW-1:0] data_boot_ofs;
    logic [7:0]             rdata;
    logic                   rvalid;
  } mmb_state_t;

  mmb_state_t s;
  mmb_state_t next_s;

  logic boot_on;
  logic code_in_boot;
  logic data_in_boot;
  logic data_in_sfr;
  logic data_in_ram;

  always_comb
  begin
    boot_on      = s.committed[MMB_BOOTROM_MAP_BIT];
    code_in_boot = (code_addr >= MMB_BOOT_LO) && (code_addr <= MMB_BOOT_HI);
    data_in_boot = (data_addr >= MMB_BOOT_LO) && (data_addr <= MMB_BOOT_HI);
    data_in_sfr  = ((data_addr >= MMB_SFR1_LO)
                    && (data_addr <= MMB_SFR1_HI))
                || ((data_addr >= MMB_SFR2_LO)
                    && (data_addr <= MMB_SFR2_HI))
                || ((data_addr >= MMB_SFR3_LO)
                    && (data_addr <= MMB_SFR3_HI));
    data_in_ram  = (data_addr >= MMB_RAM_LO)
                && (data_addr <= MMB_RAM_HI);

    next_s        = s;
    next_s.rvalid = 1'b0;
    next_s.rdata  = 8'h00;

    // Code side decode; the window only counts while mapped.
    if (code_fetch)
    begin
      next_s.code_boot_ofs = code_addr[MMB_BOOT_AW-1:0];
      if (code_in_boot && boot_on)
      begin
        next_s.code_area = MMB_AREA_BOOT;
      end
      else if (code_addr >= MMB_FLASH_LO)
      begin
        next_s.code_area = MMB_AREA_FLASH;
      end
      else
      begin
        next_s.code_area = MMB_AREA_NONE;
      end
    end

    // Data side decode.
    if (data_rd || data_wr)
    begin
      next_s.data_boot_ofs = data_addr[MMB_BOOT_AW-1:0];
      if (data_in_sfr)
      begin
        next_s.data_area = MMB_AREA_SFR;
      end
      else if (data_in_ram)
      begin
        next_s.data_area = MMB_AREA_RAM;
      end
      else if (data_in_boot && boot_on)
      begin
        next_s.data_area = MMB_AREA_BOOT;
      end
      else if (data_addr >= MMB_FLASH_LO)
      begin
        next_s.data_area = MMB_AREA_FLASH;
      end
      else
      begin
        next_s.data_area = MMB_AREA_NONE;
      end
    end

    // Register reads and the fixed answer of the unmapped window.
    if (data_rd)
    begin
      if (data_addr == MMB_FLASH_MAP_CONTROL_OFS)
      begin
        next_s.rvalid = 1'b1;
        next_s.rdata  = s.ctrl;
      end
      else if (data_addr == MMB_FLASH_MAP_SHADOW_OFS)
      begin
        next_s.rvalid = 1'b1;
        next_s.rdata  = s.committed;
      end
      else if (data_addr == MMB_MAP_COMMIT_KEY_OFS)
      begin
        next_s.rvalid = 1'b1;
        next_s.rdata  = 8'h00;
      end
      else if (data_in_boot && !boot_on)
      begin
        next_s.rvalid = 1'b1;
        next_s.rdata  = MMB_UNMAPPED_DATA;
      end
    end

    // Writes only touch the buffer; the key alone moves it across.
    if (data_wr)
    begin
      if (data_addr == MMB_FLASH_MAP_CONTROL_OFS)
      begin
        next_s.ctrl = data_wdata;
      end
      else if ((data_addr == MMB_MAP_COMMIT_KEY_OFS)
               && (data_wdata == MMB_COMMIT_KEY_FIELD))
      begin
        next_s.committed = s.ctrl;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.ctrl          <= MMB_FLASH_MAP_RESET;
      s.committed     <= MMB_FLASH_MAP_RESET;
      s.code_area     <= MMB_AREA_NONE;
      s.code_boot_ofs <= '0;
      s.data_area     <= MMB_AREA_NONE;
      s.data_boot_ofs <= '0;
      s.rdata         <= 8'h00;
      s.rvalid        <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign code_area          = s.code_area;
  assign code_boot_ofs      = s.code_boot_ofs;
  assign data_area          = s.data_area;
  assign data_boot_ofs      = s.data_boot_ofs;
  assign data_rdata         = s.rdata;
  assign data_rvalid        = s.rvalid;
  assign bootrom_map_enable = s.committed[MMB_BOOTROM_MAP_BIT];

endmodule
